// file: inc/supply_mon_pkg.sv
// Purpose: Shared constants for the power-on and supply supervision block
// Assumes: 100 MHz core clock, comparators arrive as asynchronous levels
// Notes:   Times are kept in their own unit and converted to cycles here
package supply_mon_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int DEGLITCH_US = 96;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int CNT_W = 14;
    localparam int WAIT_W = 8;
    // One startup wait step in microseconds
    localparam int WAIT_STEP_US = 1;
    localparam int WAIT_STEP_CYC = WAIT_STEP_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Settings and resets
    // ------------------------------------------------------------
    localparam int CHANNELS = 24;
    localparam int THRESH_W = 5;
    localparam int THRESH_BASE_V = 4;
    localparam int THRESH_STEP_V = 1;
    localparam logic [THRESH_W-1:0] THRESH_RST = 5'h00;
    localparam logic [WAIT_W-1:0] WAIT_RST = 8'h00;
    localparam logic [CHANNELS-1:0] ENABLE_RST = 24'h000000;
    // ------------------------------------------------------------
    // Supervisor states, Gray along power-on, wait, normal
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_WAIT = 2'b01,
        ST_NORMAL = 2'b11
    } sup_state_t;
endpackage

// file: core/deglitch_filter.sv
// Purpose: Three-stage synchroniser plus a stability timer for one level
// Assumes: Input is asynchronous to i_clk
// Notes:   Output changes only after the level stayed put for HOLD_CYC cycles
`timescale 1ns/1ps
module deglitch_filter #(
    parameter int HOLD_CYC = 9600,
    parameter int CW = 14
) (
    input wire logic i_clk, // Core clock
    input wire logic i_rst, // Async reset, high
    input wire logic i_async, // Raw comparator level
    output logic o_level // Filtered level
);
    logic s1_r, s2_r, s3_r;
    logic lvl_r, lvl_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    // Stage one is read only by stage two
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Count while a settled new level differs from the output
    always_comb begin
        lvl_nxt = lvl_r;
        cnt_nxt = '0;
        if (s2_r == s3_r && s3_r != lvl_r) begin
            if (cnt_r == CW'(HOLD_CYC - 1)) begin
                lvl_nxt = s3_r;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lvl_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            lvl_r <= lvl_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule

// file: core/power_on_supply_monitor.sv
// Purpose: Power-on reset sequencing and supply supervision flags
// Assumes: Comparators are asynchronous levels; commands are one-cycle pulses
// Notes:   Lockout inputs act as a digital-core reset through the state logic
//
// Overview of operation
// - Either supply below lockout puts the block in power-on reset.
// - Power-on reset returns every register except the stored settings to its default.
// - Each power-on reset sets power-on and summary fault flags.
// - Before both supplies are good, outputs off and fault pin driven low.
// - Both supplies good: enter startup wait, release fault pin.
// - Startup wait runs a timer from stored length, then normal.
// - Power-on clear in startup wait clears flag, stops timer, goes normal.
// - Power-up copies stored settings; others take defaults.
// - Every channel is off in power-on reset, then follows the software enable request.
// - Reload command reloads settings, defaults others, clears power-on flag.
// - Power-on clear command clears the power-on flag in any state except power-on reset.
// - Reload command bit returns to zero by itself.
// - Supply undervoltage disables channels, holds fault low, sets flags.
// - Supply below low threshold sets warning and summary flags.
// - Fault clear clears the low-supply warning with other faults.
// - Low-supply warning assertion clears open and single-short faults.
// - Below low threshold, open and single-short detection suppressed.
// - Low threshold is a 5-bit code, 4 V to 35 V.
// - Low-supply comparator deglitched for 96 us.
// - Undervoltage comparator deglitched for 96 us.
`timescale 1ns/1ps
module power_on_supply_monitor #(
    parameter int DEG_CYC = supply_mon_pkg::DEGLITCH_CYC,
    parameter int STEP_CYC = supply_mon_pkg::WAIT_STEP_CYC
) (
    input wire logic i_clk, // Core clock, 100 MHz
    input wire logic i_rst, // Async reset, high
    input wire logic i_bias_undervolt_lockout, // Battery bias below lockout
    input wire logic i_reg_undervolt_lockout, // Regulator output below lockout
    input wire logic i_supply_uv, // Output supply undervoltage comparator
    input wire logic i_supply_low, // Output supply below low threshold
    input wire logic i_power_on_flag_clear_cmd, // Clear power-on flag pulse
    input wire logic i_reload_defaults_cmd, // Reload settings pulse
    input wire logic i_fault_clear_cmd, // Clear fault flags pulse
    input wire logic [7:0] i_nv_startup_wait_length, // Stored wait length
    input wire logic [4:0] i_nv_low_supply_threshold, // Stored threshold code
    input wire logic [23:0] i_channel_enable_req, // Channel enables from software
    input wire logic [4:0] i_low_supply_threshold_wr, // Threshold write data
    input wire logic i_low_supply_threshold_we, // Threshold write strobe
    input wire logic i_open_fault_det, // Open-circuit detector hit
    input wire logic i_sls_fault_det, // Single-LED short detector hit
    output logic [1:0] o_state, // Supervisor state
    output logic o_fault_pin_o, // Fault pin output level
    output logic o_fault_pin_oe, // Fault pin pull-down enable
    output logic [23:0] o_channel_enable, // Gated channel enables
    output logic [4:0] o_low_supply_threshold, // Threshold code to comparator
    output logic [5:0] o_threshold_volts, // Threshold in volts
    output logic o_reload_defaults_cmd, // Reload bit readback
    output logic o_power_on_flag, // Power-on history flag
    output logic o_fault_flag, // Summary fault flag
    output logic o_supply_undervolt_flag, // Supply undervoltage flag
    output logic o_low_supply_warning_flag, // Low-supply warning flag
    output logic o_open_fault_flag, // Latched open-circuit fault
    output logic o_sls_fault_flag // Latched single-LED short fault
);
    // ------------------------------------------------------------
    // Comparator filtering
    // ------------------------------------------------------------
    logic uv_f, low_f, low_d_r, undervolt_lockout;
    logic [2:0] bias_sync_r, reg_sync_r;
    logic bias_lvl_r, bias_lvl_nxt, reg_lvl_r, reg_lvl_nxt;

    deglitch_filter #(.HOLD_CYC(DEG_CYC), .CW(supply_mon_pkg::CNT_W)) u_uv (
        .i_clk(i_clk), .i_rst(i_rst),
        .i_async(i_supply_uv), .o_level(uv_f));

    deglitch_filter #(.HOLD_CYC(DEG_CYC), .CW(supply_mon_pkg::CNT_W)) u_low (
        .i_clk(i_clk), .i_rst(i_rst),
        .i_async(i_supply_low), .o_level(low_f));

    // Lockout level moves only once stages two and three agree
    always_comb begin
        bias_lvl_nxt = (bias_sync_r[1] == bias_sync_r[2]) ? bias_sync_r[2] : bias_lvl_r;
        reg_lvl_nxt = (reg_sync_r[1] == reg_sync_r[2]) ? reg_sync_r[2] : reg_lvl_r;
    end
    // Reset reads as low supply, so no false good-supply edge after reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bias_sync_r <= 3'h7;
            reg_sync_r <= 3'h7;
            bias_lvl_r <= 1'b1;
            reg_lvl_r <= 1'b1;
            low_d_r <= 1'b0;
        end else begin
            bias_sync_r <= {bias_sync_r[1:0], i_bias_undervolt_lockout};
            reg_sync_r <= {reg_sync_r[1:0], i_reg_undervolt_lockout};
            bias_lvl_r <= bias_lvl_nxt;
            reg_lvl_r <= reg_lvl_nxt;
            low_d_r <= low_f;
        end
    end

    assign undervolt_lockout = bias_lvl_r | reg_lvl_r;

    // ------------------------------------------------------------
    // Supervisor state and startup timer
    // ------------------------------------------------------------
    supply_mon_pkg::sup_state_t state_r, state_nxt;
    logic [7:0] wait_len_r, wait_len_nxt, wait_cnt_r, wait_cnt_nxt;
    logic [13:0] step_r, step_nxt;

    always_comb begin
        state_nxt = state_r;
        wait_cnt_nxt = wait_cnt_r;
        step_nxt = step_r;
        case (state_r)
            supply_mon_pkg::ST_POR: begin
                wait_cnt_nxt = '0;
                step_nxt = '0;
                if (!undervolt_lockout) begin
                    state_nxt = supply_mon_pkg::ST_WAIT;
                end
            end
            supply_mon_pkg::ST_WAIT: begin
                if (i_power_on_flag_clear_cmd) begin
                    state_nxt = supply_mon_pkg::ST_NORMAL;
                end else if (wait_cnt_r >= wait_len_r) begin
                    state_nxt = supply_mon_pkg::ST_NORMAL;
                end else if (step_r == 14'(STEP_CYC - 1)) begin
                    step_nxt = '0;
                    wait_cnt_nxt = wait_cnt_r + 1'b1;
                end else begin
                    step_nxt = step_r + 1'b1;
                end
            end
            supply_mon_pkg::ST_NORMAL: begin
                wait_cnt_nxt = '0;
                step_nxt = '0;
            end
            default: begin
                state_nxt = supply_mon_pkg::ST_POR;
            end
        endcase
        if (undervolt_lockout) begin
            state_nxt = supply_mon_pkg::ST_POR;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= supply_mon_pkg::ST_POR;
            wait_cnt_r <= '0;
            step_r <= '0;
        end else begin
            state_r <= state_nxt;
            wait_cnt_r <= wait_cnt_nxt;
            step_r <= step_nxt;
        end
    end

    // ------------------------------------------------------------
    // Settings registers and flags
    // ------------------------------------------------------------
    logic in_por;
    logic [4:0] thresh_r, thresh_nxt;
    logic [23:0] en_r, en_nxt;
    logic reload_r, reload_nxt;
    logic por_r, por_nxt, err_r, err_nxt, uvf_r, uvf_nxt;
    logic lowf_r, lowf_nxt, open_r, open_nxt, sls_r, sls_nxt;

    assign in_por = (state_r == supply_mon_pkg::ST_POR);

    always_comb begin
        thresh_nxt = thresh_r;
        wait_len_nxt = wait_len_r;
        // Channels drop as soon as a lockout is seen
        en_nxt = undervolt_lockout ? supply_mon_pkg::ENABLE_RST : i_channel_enable_req;
        reload_nxt = 1'b0;
        por_nxt = por_r;
        err_nxt = err_r;
        uvf_nxt = uvf_r;
        lowf_nxt = lowf_r;
        open_nxt = open_r;
        sls_nxt = sls_r;
        if (in_por) begin
            thresh_nxt = i_nv_low_supply_threshold;
            wait_len_nxt = i_nv_startup_wait_length;
            en_nxt = supply_mon_pkg::ENABLE_RST;
            por_nxt = 1'b1;
            err_nxt = 1'b1;
            uvf_nxt = 1'b0;
            lowf_nxt = 1'b0;
            open_nxt = 1'b0;
            sls_nxt = 1'b0;
        end else begin
            if (i_low_supply_threshold_we) begin
                thresh_nxt = i_low_supply_threshold_wr;
            end
            if (i_power_on_flag_clear_cmd) begin
                por_nxt = 1'b0;
            end
            // Fault clear, and a reload, drop every fault flag
            if (i_fault_clear_cmd || i_reload_defaults_cmd) begin
                err_nxt = 1'b0;
                uvf_nxt = 1'b0;
                lowf_nxt = 1'b0;
                open_nxt = 1'b0;
                sls_nxt = 1'b0;
            end
            if (i_reload_defaults_cmd) begin
                reload_nxt = 1'b1;
                thresh_nxt = i_nv_low_supply_threshold;
                wait_len_nxt = i_nv_startup_wait_length;
                en_nxt = supply_mon_pkg::ENABLE_RST;
                por_nxt = 1'b0;
            end
            // Detection suppressed when low; set wins over clear
            if (!low_f && i_open_fault_det) begin
                open_nxt = 1'b1;
                err_nxt = 1'b1;
            end
            if (!low_f && i_sls_fault_det) begin
                sls_nxt = 1'b1;
                err_nxt = 1'b1;
            end
            // Warning onset clears open and short faults
            if (low_f && !low_d_r) begin
                open_nxt = 1'b0;
                sls_nxt = 1'b0;
            end
            if (low_f) begin
                lowf_nxt = 1'b1;
                err_nxt = 1'b1;
            end
            if (uv_f) begin
                uvf_nxt = 1'b1;
                err_nxt = 1'b1;
                en_nxt = supply_mon_pkg::ENABLE_RST;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            thresh_r <= supply_mon_pkg::THRESH_RST;
            wait_len_r <= supply_mon_pkg::WAIT_RST;
            en_r <= supply_mon_pkg::ENABLE_RST;
            reload_r <= 1'b0;
            por_r <= 1'b1;
            err_r <= 1'b1;
            uvf_r <= 1'b0;
            lowf_r <= 1'b0;
            open_r <= 1'b0;
            sls_r <= 1'b0;
        end else begin
            thresh_r <= thresh_nxt;
            wait_len_r <= wait_len_nxt;
            en_r <= en_nxt;
            reload_r <= reload_nxt;
            por_r <= por_nxt;
            err_r <= err_nxt;
            uvf_r <= uvf_nxt;
            lowf_r <= lowf_nxt;
            open_r <= open_nxt;
            sls_r <= sls_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Linear code to volts
    function automatic logic [5:0] code_volts(input logic [4:0] code);
        code_volts = 6'(supply_mon_pkg::THRESH_BASE_V)
            + 6'(code) * 6'(supply_mon_pkg::THRESH_STEP_V);
    endfunction

    assign o_state = state_r;
    // Pull fault pin low in reset; and during undervoltage
    assign o_fault_pin_o = 1'b0;
    assign o_fault_pin_oe = in_por | uv_f;
    assign o_channel_enable = en_r;
    assign o_low_supply_threshold = thresh_r;
    assign o_threshold_volts = code_volts(thresh_r);
    // Reload bit self-clears after one cycle
    assign o_reload_defaults_cmd = reload_r;
    assign o_power_on_flag = por_r;
    assign o_fault_flag = err_r;
    assign o_supply_undervolt_flag = uvf_r;
    assign o_low_supply_warning_flag = lowf_r;
    assign o_open_fault_flag = open_r;
    assign o_sls_fault_flag = sls_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_por_on_lockout: assert property (@(posedge i_clk) disable iff (i_rst)
        undervolt_lockout |=> state_r == supply_mon_pkg::ST_POR) else $error("no reset on lockout");
    a_por_flags: assert property (@(posedge i_clk) disable iff (i_rst)
        in_por |=> por_r && err_r) else $error("power-on flags not set");
    a_por_outputs: assert property (@(posedge i_clk) disable iff (i_rst)
        in_por |-> o_fault_pin_oe && en_r == '0) else $error("outputs active in reset");
    a_wait_entry: assert property (@(posedge i_clk) disable iff (i_rst)
        in_por && !undervolt_lockout |=> state_r == supply_mon_pkg::ST_WAIT) else $error("no wait entry");
    a_clear_skip: assert property (@(posedge i_clk) disable iff (i_rst)
        state_r == supply_mon_pkg::ST_WAIT && i_power_on_flag_clear_cmd && !undervolt_lockout
        |=> state_r == supply_mon_pkg::ST_NORMAL && !por_r) else $error("clear did not skip");
    a_reload_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        reload_r |=> !reload_r || $past(i_reload_defaults_cmd)) else $error("reload stuck");
    a_uv_disable: assert property (@(posedge i_clk) disable iff (i_rst)
        uv_f && !in_por |=> en_r == '0 && uvf_r) else $error("uv did not disable");
    a_low_warn: assert property (@(posedge i_clk) disable iff (i_rst)
        low_f && !in_por |=> lowf_r && err_r) else $error("low warning missing");
    a_low_suppress: assert property (@(posedge i_clk) disable iff (i_rst)
        low_f && !in_por && !open_r |=> !open_r) else $error("open raised when low");
    a_volts_map: assert property (@(posedge i_clk) disable iff (i_rst)
        o_threshold_volts == {1'b0, thresh_r} + 6'h04) else $error("threshold map wrong");

    c_wait_to_normal: cover property (@(posedge i_clk) disable iff (i_rst)
        state_r == supply_mon_pkg::ST_WAIT ##1 state_r == supply_mon_pkg::ST_NORMAL);
    c_reload: cover property (@(posedge i_clk) disable iff (i_rst) reload_r);
    c_uv_trip: cover property (@(posedge i_clk) disable iff (i_rst) uv_f && !in_por);
    c_low_warn: cover property (@(posedge i_clk) disable iff (i_rst) low_f && !low_d_r);
endmodule

// file: verif/tb.sv
// Purpose: Self-checking bench for the power-on and supply supervision block
// Assumes: Short deglitch and wait-step parameters keep the run brief
// Notes:   Inputs change on the falling edge; outputs are read there too
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    localparam int DEG = 4;
    localparam int STEP = 2;
    localparam logic [7:0] WAIT_LEN = 8'h05;
    localparam logic [4:0] NV_THR = 5'h0A;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_bias_undervolt_lockout = 1'b1;
    logic i_reg_undervolt_lockout = 1'b1;
    logic i_supply_uv = 1'b0;
    logic i_supply_low = 1'b0;
    logic i_clr_cmd = 1'b0;
    logic i_reload_cmd = 1'b0;
    logic i_fclr_cmd = 1'b0;
    logic [23:0] i_req = 24'h000000;
    logic [4:0] i_thr_wr = 5'h00;
    logic i_thr_we = 1'b0;
    logic i_open_det = 1'b0;
    logic i_sls_det = 1'b0;
    logic [1:0] o_state;
    logic o_pin_o, o_pin_oe, o_reload_echo;
    logic [23:0] o_en;
    logic [4:0] o_thr;
    logic [5:0] o_volts;
    logic o_pon, o_fault, o_uv, o_low, o_open, o_sls;
    int fails = 0;
    int tests_run = 0;

    // Free-running core clock, 100 MHz
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    power_on_supply_monitor #(.DEG_CYC(DEG), .STEP_CYC(STEP)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_bias_undervolt_lockout(i_bias_undervolt_lockout), .i_reg_undervolt_lockout(i_reg_undervolt_lockout),
        .i_supply_uv(i_supply_uv), .i_supply_low(i_supply_low),
        .i_power_on_flag_clear_cmd(i_clr_cmd), .i_reload_defaults_cmd(i_reload_cmd),
        .i_fault_clear_cmd(i_fclr_cmd), .i_nv_startup_wait_length(WAIT_LEN),
        .i_nv_low_supply_threshold(NV_THR), .i_channel_enable_req(i_req),
        .i_low_supply_threshold_wr(i_thr_wr), .i_low_supply_threshold_we(i_thr_we),
        .i_open_fault_det(i_open_det), .i_sls_fault_det(i_sls_det),
        .o_state(o_state), .o_fault_pin_o(o_pin_o), .o_fault_pin_oe(o_pin_oe),
        .o_channel_enable(o_en), .o_low_supply_threshold(o_thr),
        .o_threshold_volts(o_volts), .o_reload_defaults_cmd(o_reload_echo),
        .o_power_on_flag(o_pon), .o_fault_flag(o_fault), .o_supply_undervolt_flag(o_uv),
        .o_low_supply_warning_flag(o_low), .o_open_fault_flag(o_open),
        .o_sls_fault_flag(o_sls)
    );

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    // Compare and count; four-state equality so an unknown matches only an unknown expected bit
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Bounded wait for a state; a miss is reported by the caller's check
    task automatic wait_state(input logic [1:0] st, input int lim, output int n);
        n = 0;
        while (o_state !== st && n < lim) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic wrap_up;
        $display("Counts: comparisons=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Defaults in lockout, then startup wait timed from the stored length
    task automatic t_startup;
        int n;
        chk(o_state, 24'h0);
        chk({o_pin_oe, o_pin_o}, 24'h2);
        chk({o_pon, o_fault, o_uv, o_low, o_open, o_sls}, 24'h30);
        chk(o_en, 24'h0);
        chk(o_thr, NV_THR);
        i_bias_undervolt_lockout = 1'b0;
        i_reg_undervolt_lockout = 1'b0;
        wait_state(2'h1, 12, n);
        chk(o_state, 24'h1);
        chk(o_pin_oe, 24'h0);
        wait_state(2'h3, 40, n);
        // Allow a cycle or two of edge slack around the wait length
        chk(n >= WAIT_LEN * STEP - 1 && n <= WAIT_LEN * STEP + 2, 24'h1);
        $display("test startup done");
    endtask

    // Lockout mid-run, refused clear, then clear inside the startup wait
    task automatic t_lockout_clear;
        int n;
        i_reg_undervolt_lockout = 1'b1;
        wait_state(2'h0, 8, n);
        chk(o_state, 24'h0);
        chk({o_pon, o_fault, o_pin_oe}, 24'h7);
        i_clr_cmd = 1'b1;
        cyc(1);
        i_clr_cmd = 1'b0;
        cyc(1);
        chk(o_pon, 24'h1);
        i_reg_undervolt_lockout = 1'b0;
        wait_state(2'h1, 12, n);
        i_clr_cmd = 1'b1;
        cyc(1);
        i_clr_cmd = 1'b0;
        chk(o_state, 24'h3);
        chk(o_pon, 24'h0);
        $display("test lockout_clear done");
    endtask

    // Threshold code mapping at the top code, then reload to stored values
    task automatic t_reload;
        i_thr_wr = 5'h1F;
        i_thr_we = 1'b1;
        cyc(1);
        i_thr_we = 1'b0;
        cyc(1);
        chk(o_thr, 24'h1F);
        chk(o_volts, 24'h23);
        // Host reload after the power-on reset
        i_reload_cmd = 1'b1;
        cyc(1);
        i_reload_cmd = 1'b0;
        chk(o_reload_echo, 24'h1);
        cyc(1);
        chk(o_reload_echo, 24'h0);
        chk(o_thr, NV_THR);
        chk(o_volts, 24'h0E);
        chk({o_pon, o_fault}, 24'h0);
        $display("test reload done");
    endtask

    // Supply undervoltage: deglitch, outputs off, pin low, sticky flags
    task automatic t_supply_uv;
        i_req = 24'hFFFFFF;
        cyc(3);
        chk(o_en, 24'hFFFFFF);
        i_supply_uv = 1'b1;
        cyc(2);
        chk(o_uv, 24'h0);
        cyc(3 + DEG + 4);
        chk(o_en, 24'h0);
        chk({o_pin_oe, o_pin_o, o_uv, o_fault}, 24'hB);
        i_supply_uv = 1'b0;
        cyc(3 + DEG + 4);
        chk({o_pin_oe, o_uv, o_fault}, 24'h3);
        i_fclr_cmd = 1'b1;
        cyc(1);
        i_fclr_cmd = 1'b0;
        cyc(1);
        chk({o_uv, o_fault}, 24'h0);
        $display("test supply_uv done");
    endtask

    // Low-supply warning clears and blocks open and single-short faults
    task automatic t_low_supply;
        i_open_det = 1'b1;
        i_sls_det = 1'b1;
        cyc(1);
        i_open_det = 1'b0;
        i_sls_det = 1'b0;
        cyc(1);
        chk({o_open, o_sls}, 24'h3);
        i_supply_low = 1'b1;
        cyc(2);
        chk(o_low, 24'h0);
        cyc(3 + DEG + 4);
        chk({o_low, o_fault, o_open, o_sls}, 24'hC);
        i_open_det = 1'b1;
        i_sls_det = 1'b1;
        cyc(2);
        i_open_det = 1'b0;
        i_sls_det = 1'b0;
        chk({o_open, o_sls}, 24'h0);
        i_supply_low = 1'b0;
        cyc(3 + DEG + 4);
        chk({o_low, o_fault}, 24'h3);
        i_fclr_cmd = 1'b1;
        cyc(1);
        i_fclr_cmd = 1'b0;
        cyc(1);
        chk({o_low, o_fault}, 24'h0);
        $display("test low_supply done");
    endtask

    // Second lockout mid-run on the bias input: flags set again, clear in normal
    task automatic t_relock;
        int n;
        i_bias_undervolt_lockout = 1'b1;
        wait_state(2'h0, 10, n);
        chk(o_en, 24'h0);
        cyc(1);
        chk({o_pon, o_fault, o_pin_oe}, 24'h7);
        i_bias_undervolt_lockout = 1'b0;
        wait_state(2'h1, 12, n);
        wait_state(2'h3, 40, n);
        chk(o_state, 24'h3);
        i_clr_cmd = 1'b1;
        cyc(1);
        i_clr_cmd = 1'b0;
        chk({o_pon, o_fault}, 24'h1);
        // Host reload after the power-on reset
        i_reload_cmd = 1'b1;
        cyc(1);
        i_reload_cmd = 1'b0;
        chk({o_reload_echo, o_fault, o_en[0]}, 24'h4);
        $display("test relock done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(12);
        i_rst = 1'b0;
        cyc(4);
        t_startup();
        t_lockout_clear();
        t_reload();
        t_supply_uv();
        t_low_supply();
        t_relock();
        wrap_up();
    end

    // Whole run is about 130 cycles; this span leaves wide margin
    initial begin
        #100us;
        fails++;
        wrap_up();
    end
endmodule
